//--- logic/cirs_pkg.sv
// constants, field layouts and carrier types for the current-loop input readout
// assumes a single 100 MHz clock domain and a same-clock converter handshake
// Functional notes
// - every enabled channel is converted again within each 45 ms update period.
// - each channel selects 0-20 mA or 4-20 mA, and 4-20 mA is the reset default.
// - raw counts run from 0 to 16383 in both ranges, 1.22 uA or 0.977 uA per count.
// - raw results are always 14 bits and the 16-bit unipolar option has no effect.
// - status occupies 24 bits on a byte boundary.
// - byte 0 holds self-test failed, supply missing and data not valid in bits 0 to 2.
// - byte 1 holds the open-loop flags of channels 1 to 4 in bits 0 to 3.
// - byte 2 holds no flags and reads as zero.
// - an open-loop flag sets only in the 4-20 mA range below about 3.75 mA.
// - data not valid stays set until the latest configuration has been loaded; a commit clears it while its own control bits stay in the shadow.
// - self-test failed is set while the internal self-test does not pass.
// - supply missing is set while the external 24 V field supply is absent.
// - only the configured number of channels is converted, shortening the cycle.
// - with scaling on, raw min..max maps linearly onto engineering min..max.
// - with clamping on, the scaled value is held within engineering min..max.
package cirs_pkg;
    localparam int CIRS_NCH = 4;
    localparam int CIRS_RAW_W = 14;
    localparam int CIRS_ENG_W = 16;
    localparam logic [13:0] CIRS_RAW_TOP = 14'h3fff;
    // timing
    localparam longint CIRS_CLK_HZ = 100000000;
    localparam longint CIRS_UPDATE_MS = 45;
    localparam int CIRS_UPDATE_CYC = int'((CIRS_UPDATE_MS * CIRS_CLK_HZ) / 1000);
    // converter code is 0-20 mA full scale; 4 mA and 3.75 mA points
    localparam logic [13:0] CIRS_CODE_4MA = 14'h0ccf;
    localparam logic [13:0] CIRS_CODE_OPEN = 14'h0c02;
    // 4-20 mA gain in Q14, stretches 4..20 mA back over the full 14 bits
    localparam logic [16:0] CIRS_GAIN_4_20 = 17'h05004;
    // register byte offsets
    localparam logic [7:0] CIRS_A_STATUS = 8'h00;
    localparam logic [7:0] CIRS_A_CTRL = 8'h04;
    localparam logic [7:0] CIRS_A_RMIN = 8'h08;
    localparam logic [7:0] CIRS_A_RMAX = 8'h0c;
    localparam logic [7:0] CIRS_A_EMIN = 8'h10;
    localparam logic [7:0] CIRS_A_EMAX = 8'h14;
    localparam logic [7:0] CIRS_A_IST = 8'h18;
    localparam logic [7:0] CIRS_A_IMSK = 8'h1c;
    localparam logic [7:0] CIRS_A_RAW0 = 8'h20;
    localparam logic [7:0] CIRS_A_SCL0 = 8'h30;
    // control word fields
    localparam int CIRS_C_SCALE = 3;
    localparam int CIRS_C_CLAMP = 4;
    localparam int CIRS_C_RANGE = 5;
    localparam int CIRS_C_COMMIT = 31;
    localparam logic [2:0] CIRS_CNT_RST = 3'h4;
    localparam logic [3:0] CIRS_RANGE_RST = 4'hf;
    // interrupt status bits
    localparam int CIRS_I_CYCLE = 0;
    localparam int CIRS_I_OPEN = 1;
    localparam int CIRS_I_SUPPLY = 2;
    localparam int CIRS_I_TEST = 3;
    localparam int CIRS_I_W = 4;

    typedef struct packed {
        logic [2:0] chan_count;
        logic scale_en;
        logic clamp_scaled_enable;
        logic [3:0] range_4_20;
    } cirs_cfg_t;

    typedef struct packed {
        logic [13:0] raw_min;
        logic [13:0] raw_max;
        logic signed [15:0] eng_min;
        logic signed [15:0] eng_max;
    } cirs_scl_t;
endpackage

//--- logic/cirs_sync.sv
// two-flop synchroniser for a group of asynchronous level inputs
// assumes the inputs are slow levels, so each bit may settle independently
`timescale 1ns/10ps
module cirs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) begin
            $error("cirs_sync width must be at least one");
        end
    end

    // first stage is read only by the second
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // cirs_sync

//--- logic/cirs_scaler.sv
// linear raw-to-engineering scaler with optional clamp, purely combinational
// assumes raw_max > raw_min; a zero span passes eng_min through
`timescale 1ns/10ps
module cirs_scaler
    import cirs_pkg::*;
(
    // operands
    input wire logic [13:0] i_raw,
    input wire cirs_scl_t i_scl,
    input wire logic i_scale_en,
    input wire logic i_clamp_en,
    // result
    output logic signed [15:0] o_value
);
    logic signed [15:0] dr;
    logic signed [15:0] span_r;
    logic signed [16:0] span_e;
    logic signed [33:0] prod;
    logic signed [33:0] quot;
    logic signed [33:0] sum;
    logic signed [15:0] lo;
    logic signed [15:0] hi;

    // map, then optionally clamp
    always_comb begin
        dr = $signed({2'b00, i_raw}) - $signed({2'b00, i_scl.raw_min});
        span_r = $signed({2'b00, i_scl.raw_max}) - $signed({2'b00, i_scl.raw_min});
        span_e = 17'(i_scl.eng_max) - 17'(i_scl.eng_min);
        prod = 34'(dr) * 34'(span_e);
        quot = (span_r == 16'sh0000) ? 34'sh0 : prod / 34'(span_r);
        sum = quot + 34'(i_scl.eng_min);
        lo = (i_scl.eng_min < i_scl.eng_max) ? i_scl.eng_min : i_scl.eng_max;
        hi = (i_scl.eng_min < i_scl.eng_max) ? i_scl.eng_max : i_scl.eng_min;
        if (!i_scale_en) begin
            o_value = $signed({2'b00, i_raw});
        end else if (i_clamp_en && sum < 34'(lo)) begin
            o_value = lo;
        end else if (i_clamp_en && sum > 34'(hi)) begin
            o_value = hi;
        end else begin
            o_value = sum[15:0]; // wraps when unclamped and out of range
        end
    end
endmodule // cirs_scaler

//--- logic/cirs_readout.sv
// four-channel current-loop readout: sequencer, range conversion, status and registers
// assumes a converter on the same clock: start pulse in, done pulse with code out
`timescale 1ns/10ps
module cirs_readout
    import cirs_pkg::*;
#(
    parameter int UPDATE_CYC = CIRS_UPDATE_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // converter handshake
    output logic o_adc_start,
    output logic [1:0] o_adc_chan,
    input wire logic i_adc_done,
    input wire logic [13:0] i_adc_code,
    // field pins
    input wire logic i_supply_ok,
    input wire logic i_selftest_fail,
    // status image and interrupt
    output logic [23:0] o_status,
    output logic o_irq
);
    localparam int SLOT_CYC = UPDATE_CYC / CIRS_NCH;

    initial begin
        if (SLOT_CYC < 2) begin
            $error("update period too short for four slots");
        end
    end

    typedef enum logic [2:0] {
        CIRS_IDLE = 3'b001,
        CIRS_CONV = 3'b010,
        CIRS_STORE = 3'b100
    } cirs_state_t;

    cirs_state_t state_r;
    cirs_cfg_t cfg_r;
    cirs_cfg_t cfg_sh_r;
    cirs_scl_t scl_r;
    cirs_scl_t scl_sh_r;
    logic valid_r;
    logic [31:0] slot_r;
    logic [1:0] ch_r;
    logic [13:0] code_r;
    logic [13:0] raw_r [CIRS_NCH];
    logic signed [15:0] val_r [CIRS_NCH];
    logic [3:0] open_r;
    logic [CIRS_I_W-1:0] ist_r;
    logic [CIRS_I_W-1:0] imsk_r;
    logic [1:0] pins;
    logic supply_absent;
    logic test_fail;
    logic [13:0] raw_nxt;
    logic [30:0] gained;
    logic [13:0] above;
    logic signed [15:0] val_nxt;
    logic slot_tick;
    logic last_ch;
    logic [3:0] open_nxt;
    logic [2:0] mod_flags;
    logic [2:0] mod_flags_q;
    logic [3:0] open_q;
    logic [CIRS_I_W-1:0] ev;
    logic ctrl_wr;
    logic shadow_wr;

    // field pins come from outside the clock domain
    cirs_sync #(
        .WIDTH(2)
    ) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({i_supply_ok, i_selftest_fail}),
        .o_sync(pins)
    );
    assign supply_absent = !pins[1];
    assign test_fail = pins[0];

    // range conversion of the converter code
    always_comb begin
        above = (i_adc_code > CIRS_CODE_4MA) ? 14'(i_adc_code - CIRS_CODE_4MA) : 14'h0000;
        gained = 31'(above) * 31'(CIRS_GAIN_4_20);
        if (!cfg_r.range_4_20[ch_r]) begin
            raw_nxt = i_adc_code;
        end else if (gained[30:14] > 17'(CIRS_RAW_TOP)) begin
            raw_nxt = CIRS_RAW_TOP;
        end else begin
            raw_nxt = gained[27:14];
        end
    end

    // one shared scaler, time-multiplexed across channels
    cirs_scaler u_scaler (
        .i_raw(code_r),
        .i_scl(scl_r),
        .i_scale_en(cfg_r.scale_en),
        .i_clamp_en(cfg_r.clamp_scaled_enable),
        .o_value(val_nxt)
    );

    assign slot_tick = (slot_r == 32'h0000_0000);
    assign last_ch = (3'(ch_r) + 3'h1 >= cfg_r.chan_count);

    // slot timer: one conversion slot per enabled channel
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            slot_r <= 32'h0000_0000;
        end else if (slot_tick) begin
            slot_r <= 32'(SLOT_CYC - 1);
        end else begin
            slot_r <= slot_r - 32'h0000_0001;
        end
    end

    // conversion sequencer
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= CIRS_IDLE;
            ch_r <= 2'h0;
            code_r <= 14'h0000;
            o_adc_start <= 1'b0;
            o_adc_chan <= 2'h0;
        end else begin
            o_adc_start <= 1'b0;
            case (state_r)
                CIRS_IDLE: begin
                    if (slot_tick) begin
                        o_adc_start <= 1'b1;
                        // a commit may shrink the count while ch_r points past it
                        if (3'(ch_r) < cfg_r.chan_count) begin
                            o_adc_chan <= ch_r;
                        end else begin
                            o_adc_chan <= 2'h0;
                            ch_r <= 2'h0;
                        end
                        state_r <= CIRS_CONV;
                    end
                end
                CIRS_CONV: begin
                    if (i_adc_done) begin
                        code_r <= raw_nxt;
                        state_r <= CIRS_STORE;
                    end
                end
                CIRS_STORE: begin
                    ch_r <= last_ch ? 2'h0 : 2'(ch_r + 2'h1);
                    state_r <= CIRS_IDLE;
                end
                default: begin
                    state_r <= CIRS_IDLE;
                end
            endcase
        end
    end

    // per-channel results and open-loop flags
    always_comb begin
        open_nxt = open_r;
        for (int i = 0; i < CIRS_NCH; i++) begin
            if (3'(i) >= cfg_r.chan_count || !cfg_r.range_4_20[i]) begin
                open_nxt[i] = 1'b0;
            end
        end
        if (state_r == CIRS_CONV && i_adc_done) begin
            open_nxt[ch_r] = cfg_r.range_4_20[ch_r] && (i_adc_code < CIRS_CODE_OPEN);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            open_r <= 4'h0;
            for (int i = 0; i < CIRS_NCH; i++) begin
                raw_r[i] <= 14'h0000;
                val_r[i] <= 16'sh0000;
            end
        end else begin
            open_r <= open_nxt;
            if (state_r == CIRS_STORE) begin
                raw_r[ch_r] <= code_r;
                val_r[ch_r] <= val_nxt;
            end
        end
    end

    // configuration: shadow writes stale the data until a commit loads them
    assign ctrl_wr = i_wr && (i_addr == CIRS_A_CTRL);
    assign shadow_wr = i_wr && (i_addr == CIRS_A_RMIN || i_addr == CIRS_A_RMAX ||
                                i_addr == CIRS_A_EMIN || i_addr == CIRS_A_EMAX || ctrl_wr);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_sh_r <= '{chan_count: CIRS_CNT_RST, scale_en: 1'b0, clamp_scaled_enable: 1'b0,
                          range_4_20: CIRS_RANGE_RST};
            scl_sh_r <= '{raw_min: 14'h0000, raw_max: CIRS_RAW_TOP, eng_min: 16'sh0000,
                          eng_max: 16'sh3fff};
        end else if (ctrl_wr) begin
            cfg_sh_r.chan_count <= (i_wdata[2:0] == 3'h0 || i_wdata[2:0] > CIRS_CNT_RST) ?
                                   CIRS_CNT_RST : i_wdata[2:0];
            cfg_sh_r.scale_en <= i_wdata[CIRS_C_SCALE];
            cfg_sh_r.clamp_scaled_enable <= i_wdata[CIRS_C_CLAMP];
            cfg_sh_r.range_4_20 <= i_wdata[CIRS_C_RANGE +: 4];
            // bit 9, the 16-bit unipolar option, is not stored at all
        end else if (i_wr) begin
            case (i_addr)
                CIRS_A_RMIN: scl_sh_r.raw_min <= i_wdata[13:0];
                CIRS_A_RMAX: scl_sh_r.raw_max <= i_wdata[13:0];
                CIRS_A_EMIN: scl_sh_r.eng_min <= i_wdata[15:0];
                CIRS_A_EMAX: scl_sh_r.eng_max <= i_wdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // active set; never configured counts as not valid
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_r <= '{chan_count: CIRS_CNT_RST, scale_en: 1'b0, clamp_scaled_enable: 1'b0,
                       range_4_20: CIRS_RANGE_RST};
            scl_r <= '{raw_min: 14'h0000, raw_max: CIRS_RAW_TOP, eng_min: 16'sh0000,
                       eng_max: 16'sh3fff};
            valid_r <= 1'b0;
        end else if (ctrl_wr && i_wdata[CIRS_C_COMMIT]) begin
            cfg_r <= cfg_sh_r;
            scl_r <= scl_sh_r;
            valid_r <= 1'b1;
        end else if (shadow_wr) begin
            valid_r <= 1'b0;
        end
    end

    // status image, byte 2 stays zero
    assign mod_flags = {!valid_r, supply_absent, test_fail};
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status <= 24'h000001 << 2;
            // sync resets low, so supply reads absent until filled; no false event
            mod_flags_q <= 3'h6;
            open_q <= 4'h0;
        end else begin
            o_status <= {8'h00, 4'h0, open_r, 5'h00, mod_flags};
            mod_flags_q <= mod_flags;
            open_q <= open_r;
        end
    end

    // sticky events, set wins over a write-one clear
    assign ev[CIRS_I_CYCLE] = (state_r == CIRS_STORE) && last_ch;
    assign ev[CIRS_I_OPEN] = |(open_r & ~open_q);
    assign ev[CIRS_I_SUPPLY] = mod_flags[1] && !mod_flags_q[1];
    assign ev[CIRS_I_TEST] = mod_flags[0] && !mod_flags_q[0];

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ist_r <= '0;
            imsk_r <= '0;
            o_irq <= 1'b0;
        end else begin
            if (i_wr && i_addr == CIRS_A_IST) begin
                ist_r <= (ist_r & ~i_wdata[CIRS_I_W-1:0]) | ev;
            end else begin
                ist_r <= ist_r | ev;
            end
            if (i_wr && i_addr == CIRS_A_IMSK) begin
                imsk_r <= i_wdata[CIRS_I_W-1:0];
            end
            o_irq <= |(ist_r & imsk_r);
        end
    end

    // read port, data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                CIRS_A_STATUS: o_rdata <= {8'h00, o_status};
                CIRS_A_CTRL: o_rdata <= {23'h000000, cfg_sh_r.range_4_20, cfg_sh_r.clamp_scaled_enable,
                                         cfg_sh_r.scale_en, cfg_sh_r.chan_count};
                CIRS_A_RMIN: o_rdata <= {18'h00000, scl_sh_r.raw_min};
                CIRS_A_RMAX: o_rdata <= {18'h00000, scl_sh_r.raw_max};
                CIRS_A_EMIN: o_rdata <= {{16{scl_sh_r.eng_min[15]}}, scl_sh_r.eng_min};
                CIRS_A_EMAX: o_rdata <= {{16{scl_sh_r.eng_max[15]}}, scl_sh_r.eng_max};
                CIRS_A_IST: o_rdata <= {28'h0000000, ist_r};
                CIRS_A_IMSK: o_rdata <= {28'h0000000, imsk_r};
                CIRS_A_RAW0, 8'h24, 8'h28, 8'h2c: o_rdata <= {18'h00000, raw_r[i_addr[3:2]]};
                CIRS_A_SCL0, 8'h34, 8'h38, 8'h3c: o_rdata <= {{16{val_r[i_addr[3:2]][15]}}, val_r[i_addr[3:2]]};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // checks
    logic [31:0] since_start_r;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            since_start_r <= 32'h0000_0000;
        end else if (o_adc_start && o_adc_chan == 2'h0) begin
            since_start_r <= 32'h0000_0000;
        end else begin
            since_start_r <= since_start_r + 32'h0000_0001;
        end
    end

    refresh_bound_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        since_start_r <= 32'(UPDATE_CYC)) else $error("channel one not restarted within the update period");
    start_chan_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_adc_start |-> 3'(o_adc_chan) < cfg_r.chan_count) else $error("disabled channel converted");
    raw_limit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_r == CIRS_CONV && i_adc_done && !cfg_r.range_4_20[ch_r])
        |=> code_r == $past(i_adc_code)) else $error("0-20 mA raw differs from code");
    open_range_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_r == CIRS_CONV && i_adc_done && !cfg_r.range_4_20[ch_r])
        |=> !open_r[$past(ch_r)]) else $error("open flag in 0-20 mA range");
    open_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_r == CIRS_CONV && i_adc_done && cfg_r.range_4_20[ch_r] && i_adc_code < CIRS_CODE_OPEN)
        |-> ##2 o_status[8 + $past(ch_r, 2)]) else $error("open flag missing in status");
    status_top_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_status[23:16] == 8'h00 && o_status[15:12] == 4'h0 && o_status[7:3] == 5'h00)
        else $error("spare status bits set");
    stale_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (shadow_wr && !(ctrl_wr && i_wdata[CIRS_C_COMMIT])) |-> ##2 o_status[2])
        else $error("data not valid missing after stale write");
    commit_ok_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (ctrl_wr && i_wdata[CIRS_C_COMMIT]) ##1 !shadow_wr |-> ##1 !o_status[2])
        else $error("data not valid stuck after commit");
    supply_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $fell(pins[1]) |=> o_status[1]) else $error("supply missing flag late");
    test_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $fell(pins[0]) |=> !o_status[0]) else $error("self-test flag not cleared");
    clamp_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_r == CIRS_STORE && cfg_r.scale_en && cfg_r.clamp_scaled_enable
         && scl_r.eng_min <= scl_r.eng_max)
        |=> val_r[$past(ch_r)] >= $past(scl_r.eng_min) && val_r[$past(ch_r)] <= $past(scl_r.eng_max))
        else $error("scaled value outside clamp");
endmodule // cirs_readout

//--- sim/cirs_adc_model.sv
// converter stand-in: answers each start with the code set for its channel
// assumes start and channel come from the readout on the same clock
`timescale 1ns/10ps
module cirs_adc_model (
    // clock and request
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic [1:0] i_chan,
    // codes per channel and answer delay in cycles
    input wire logic [13:0] i_codes [4],
    input wire logic [7:0] i_delay,
    // answer
    output logic o_done,
    output logic [13:0] o_code
);
    // one conversion at a time; code line zero before the first answer, then inverted outside the done cycle
    // so a design that samples it late cannot see a plausible value
    initial begin
        o_done = 1'b0;
        o_code = 14'h0000;
        forever begin
            @(posedge i_clk);
            if (i_start) begin
                repeat (i_delay) @(posedge i_clk);
                o_done <= 1'b1;
                o_code <= i_codes[i_chan];
                @(posedge i_clk);
                o_done <= 1'b0;
                o_code <= ~i_codes[i_chan];
            end
        end
    end
endmodule // cirs_adc_model

//--- sim/cirs_readout_tb_top.sv
// register-level bench for the readout, slot shortened to 100 cycles
// assumes the converter model answers within a slot
`timescale 1ns/10ps
module cirs_readout_tb_top;
    import cirs_pkg::*;
    logic i_clk, i_nrst, i_wr, i_rd, i_supply_ok, i_selftest_fail;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic o_adc_start, o_irq, adc_done;
    logic [1:0] o_adc_chan, maxch;
    logic [13:0] adc_code;
    logic [23:0] o_status;
    logic [13:0] codes [4];
    logic [7:0] delay;
    int fails, comparisons, nstart;

    cirs_readout #(.UPDATE_CYC(400)) u_cirs_readout (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_adc_start(o_adc_start),
        .o_adc_chan(o_adc_chan), .i_adc_done(adc_done), .i_adc_code(adc_code), .i_supply_ok(i_supply_ok),
        .i_selftest_fail(i_selftest_fail), .o_status(o_status), .o_irq(o_irq));
    cirs_adc_model u_cirs_adc_model (.i_clk(i_clk), .i_start(o_adc_start), .i_chan(o_adc_chan),
        .i_codes(codes), .i_delay(delay), .o_done(adc_done), .o_code(adc_code));

    // clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // start pulse census on the falling edge, so a window never counts one twice
    always @(negedge i_clk) begin
        if (o_adc_start === 1'b1) begin
            nstart++;
            if (o_adc_chan > maxch) maxch = o_adc_chan;
        end
    end

    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // one-cycle strobes, a free cycle after each so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clk);
        ck($sformatf("reg %h", a), e, d);
    endtask
    task automatic wirq(input logic e);
        int n;
        n = 0;
        while (o_irq !== e && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        ck("irq", {31'h0, e}, {31'h0, o_irq});
        if (o_irq !== e) complete_run();
    endtask
    task automatic commit(input logic [31:0] c);
        wr(CIRS_A_CTRL, c);
        wr(CIRS_A_CTRL, c | 32'h80000000);
        repeat (500) @(posedge i_clk);
    endtask
    // expected 4-20 mA counts: offset removed, stretched, saturated
    function automatic logic [31:0] raw420(input logic [13:0] c);
        logic [31:0] t;
        t = (c > CIRS_CODE_4MA) ? ((32'(c) - 32'(CIRS_CODE_4MA)) * 32'(CIRS_GAIN_4_20)) >> 14 : 32'h0;
        return (t > 32'(CIRS_RAW_TOP)) ? 32'(CIRS_RAW_TOP) : t;
    endfunction
    // raw 1000..3000 onto 0..200, truncating toward zero
    function automatic logic [31:0] scl(input logic [13:0] r, input bit c);
        int v;
        v = ((int'(r) - 1000) * 200) / 2000;
        if (c) v = (v > 200) ? 200 : ((v < 0) ? 0 : v);
        return 32'(v);
    endfunction

    initial begin
        i_nrst = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_supply_ok = 1'b1;
        i_selftest_fail = 1'b0;
        codes = '{14'h0bb8, 14'h3fff, 14'h0c02, 14'h0c01};
        delay = 8'h3c;
        maxch = 2'h0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        rc(CIRS_A_STATUS, 32'h4);
        rc(CIRS_A_CTRL, 32'h1e4);
        wr(CIRS_A_CTRL, 32'h3e4);
        rc(CIRS_A_CTRL, 32'h1e4);
        commit(32'h1e4);
        rc(CIRS_A_STATUS, 32'h900);
        ck("status image", 32'h900, {8'h00, o_status});
        for (int k = 0; k < 4; k++) rc(CIRS_A_RAW0 + 8'(4 * k), raw420(codes[k]));
        nstart = 0;
        repeat (400) @(posedge i_clk);
        ck("starts", 32'h4, 32'(nstart));
        // pending scaling set raises data not valid until committed
        delay = 8'h00;
        wr(CIRS_A_RMIN, 32'h3e8);
        rc(CIRS_A_STATUS, 32'h904);
        wr(CIRS_A_RMAX, 32'hbb8);
        wr(CIRS_A_EMIN, 32'h0);
        wr(CIRS_A_EMAX, 32'hc8);
        commit(32'hc);
        rc(CIRS_A_STATUS, 32'h0);
        for (int k = 0; k < 4; k++) rc(CIRS_A_RAW0 + 8'(4 * k), 32'(codes[k]));
        for (int k = 0; k < 4; k++) rc(CIRS_A_SCL0 + 8'(4 * k), scl(codes[k], 1'b0));
        commit(32'h1c);
        for (int k = 0; k < 4; k++) rc(CIRS_A_SCL0 + 8'(4 * k), scl(codes[k], 1'b1));
        commit(32'h2);
        nstart = 0;
        maxch = 2'h0;
        repeat (400) @(posedge i_clk);
        ck("starts", 32'h4, 32'(nstart));
        ck("top channel", 32'h1, 32'(maxch));
        // field faults: supply loss interrupts, self-test flag follows pin
        wr(CIRS_A_IMSK, 32'h4);
        wr(CIRS_A_IST, 32'hf);
        wirq(1'b0);
        i_supply_ok <= 1'b0;
        i_selftest_fail <= 1'b1;
        repeat (5) @(posedge i_clk);
        rc(CIRS_A_STATUS, 32'h3);
        wirq(1'b1);
        i_supply_ok <= 1'b1;
        i_selftest_fail <= 1'b0;
        repeat (5) @(posedge i_clk);
        rc(CIRS_A_STATUS, 32'h0);
        wr(CIRS_A_IMSK, 32'h0);
        wirq(1'b0);
        wr(CIRS_A_IMSK, 32'h4);
        wirq(1'b1);
        wr(CIRS_A_IST, 32'h4);
        wirq(1'b0);
        rc(8'hfc, 32'h0);
        complete_run();
    end
endmodule // cirs_readout_tb_top
